// ==== scc_host.sv ====
module scc_host (
	input  wire logic ref_clk,
	input  wire logic line,
	output logic      smb_clk,
	output logic      host_low
);
	timeunit 1ns;
	timeprecision 1ps;

	// ========================================
	// Idle bus: clock stands high, data released
	initial begin
		smb_clk  = 1'b1;
		host_low = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wt

	task automatic start();
		wt(4);
		host_low = 1'b1;
		wt(4);
		smb_clk = 1'b0;
	endtask : start

	// Longer phases, since the device may still hold its acknowledge
	task automatic rstart();
		wt(3);
		host_low = 1'b0;
		wt(3);
		smb_clk = 1'b1;
		wt(3);
		host_low = 1'b1;
		wt(3);
		smb_clk = 1'b0;
	endtask : rstart

	task automatic stop();
		wt(3);
		host_low = 1'b1;
		wt(3);
		smb_clk = 1'b1;
		wt(3);
		host_low = 1'b0;
	endtask : stop

	// ========================================
	// One link bit: 100 ns low, 100 ns high
	task automatic bit_io(input logic b, output logic r);
		wt(2);
		host_low = ~b;
		wt(2);
		smb_clk = 1'b1;
		wt(2);
		r = line;
		wt(2);
		smb_clk = 1'b0;
	endtask : bit_io

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wr_byte

	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask : rd_byte

endmodule : scc_host

// ==== scc_pkg.sv ====
// ============================================================
package scc_pkg;

	// ============================================================
	// Bus addresses and register map
	localparam logic [7:0] ADDR_RD   = 8'hd2;
	localparam logic [7:0] ADDR_WR   = 8'hd3;
	localparam int         NUM_REGS  = 10;
	localparam logic [7:0] IDX_CTRL  = 8'h00;
	localparam logic [7:0] IDX_OEA   = 8'h01;
	localparam logic [7:0] IDX_OEB   = 8'h03;
	localparam logic [7:0] IDX_AMP   = 8'h05;
	localparam logic [7:0] IDX_ID    = 8'h07;
	localparam logic [7:0] IDX_COUNT = 8'h08;
	localparam logic [7:0] IDX_OEC   = 8'h09;

	// ============================================================
	// Field positions
	localparam int SPREAD_BIT = 5;
	localparam int OUT0_BIT   = 6;
	localparam int OUT1_BIT   = 3;
	localparam int OUT5_BIT   = 7;
	localparam int OUT4_BIT   = 6;
	localparam int OUT3_BIT   = 6;
	localparam int OUT2_BIT   = 5;
	localparam int AMP_HI_LSB = 6;
	localparam int AMP_MD_LSB = 4;
	localparam int AMP_LO_LSB = 0;

	// ============================================================
	// Reset values and writable bits, index 9 down to 0
	localparam logic [NUM_REGS-1:0][7:0] RST_VAL = {
		8'h60, 8'h09, 8'h00, 8'h00, 8'h51,
		8'h00, 8'hc0, 8'h00, 8'h48, 8'h20};
	localparam logic [NUM_REGS-1:0][7:0] RW_MASK = {
		8'h60, 8'hff, 8'h00, 8'h00, 8'hf3,
		8'h00, 8'hc0, 8'h00, 8'h48, 8'h20};

	// ============================================================
	// Counts
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT   = 4'h7;

	// ============================================================
	// Link state and byte role
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b011,
		ST_TX   = 3'b010,
		ST_RACK = 3'b110
	} scc_st_e;

	typedef enum logic [1:0] {
		RO_ADDR  = 2'b00,
		RO_INDEX = 2'b01,
		RO_COUNT = 2'b11,
		RO_DATA  = 2'b10
	} scc_role_e;

endpackage : scc_pkg

// ==== scc_regs.sv ====
module scc_regs
	import scc_pkg::*;
#(
	parameter logic [3:0] REV_ID = 4'h2,  // Arbitrary value
	parameter logic [3:0] VEN_ID = 4'ha,  // Arbitrary value
	parameter int         DIV    = 2
) (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       smb_clk,
	input  wire logic       smb_data_in,
	output logic            smb_data_out,
	output logic            smb_data_oe,
	output logic      [5:0] diff_clock_pair_true,
	output logic      [5:0] diff_clock_pair_comp,
	output logic            spread_enable,
	output logic      [1:0] amp_hi,
	output logic      [1:0] amp_mid,
	output logic      [1:0] amp_lo
);
	localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

	typedef struct packed {
		scc_st_e                  st;
		scc_role_e                role;
		logic                     rd_mode;
		logic [3:0]               bit_cnt;
		logic [7:0]               sh;
		logic [7:0]               idx;
		logic                     ack_ok;
		logic                     scl_d;
		logic                     sda_d;
		logic                     oe;
		logic [NUM_REGS-1:0][7:0] regs;
		logic [DIV_W-1:0]         div;
		logic                     phase;
		logic [5:0]               tru;
		logic [5:0]               cmp;
		logic                     spread;
		logic [5:0]               amp;
	} scc_state_s;

	scc_state_s r;
	scc_state_s n;

	logic [1:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       rx_done;
	logic [5:0] en;

	// ============================================================
	// Pin sampling
	scc_sync #(.W(2)) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.din     ({smb_clk, smb_data_in}),
		.dout    (pins_s)
	);

	assign scl_s    = pins_s[1];
	assign sda_s    = pins_s[0];
	assign scl_rise = scl_s & ~r.scl_d;
	assign scl_fall = ~scl_s & r.scl_d;
	assign start_c  = scl_s & r.scl_d & r.sda_d & ~sda_s;
	assign stop_c   = scl_s & r.scl_d & ~r.sda_d & sda_s;
	assign rx_done  = (r.st == ST_RX) && scl_fall &&
		(r.bit_cnt == BITS_PER_BYTE);

	assign en[0] = r.regs[IDX_OEA][OUT0_BIT];
	assign en[1] = r.regs[IDX_OEA][OUT1_BIT];
	assign en[2] = r.regs[IDX_OEC][OUT2_BIT];
	assign en[3] = r.regs[IDX_OEC][OUT3_BIT];
	assign en[4] = r.regs[IDX_OEB][OUT4_BIT];
	assign en[5] = r.regs[IDX_OEB][OUT5_BIT];

	// ============================================================
	// Register read view
	function automatic logic [7:0] reg_read(
		input logic [NUM_REGS-1:0][7:0] regs,
		input logic [7:0]               idx
	);
		logic [7:0] v;
		v = 8'h00;
		if (idx == IDX_ID) begin
			v = {REV_ID, VEN_ID};
		end else if (idx < 8'(NUM_REGS)) begin
			v = regs[idx[3:0]];
		end
		return v;
	endfunction : reg_read

	// ============================================================
	// Next state
	always_comb begin
		logic do_load;
		do_load = 1'b0;
		n       = r;
		n.scl_d = scl_s;
		n.sda_d = sda_s;

		case (r.st)
			ST_IDLE: begin
				n.oe = 1'b0;
			end
			ST_RX: begin
				if (scl_rise) begin
					n.sh      = {r.sh[6:0], sda_s};
					n.bit_cnt = r.bit_cnt + 4'h1;
				end else if (scl_fall && r.bit_cnt == BITS_PER_BYTE) begin
					n.bit_cnt = 4'h0;
					n.st      = ST_ACK;
					n.oe      = 1'b1;
					case (r.role)
						RO_ADDR: begin
							if (r.sh == ADDR_WR) begin
								n.rd_mode = 1'b0;
								n.role    = RO_INDEX;
							end else if (r.sh == ADDR_RD) begin
								n.rd_mode = 1'b1;
								n.role    = RO_COUNT;
							end else begin
								n.st = ST_IDLE;
								n.oe = 1'b0;
							end
						end
						RO_INDEX: begin
							n.idx  = r.sh;
							n.role = RO_COUNT;
						end
						RO_COUNT: begin
							n.role = RO_DATA;
						end
						default: begin
							if (r.idx < 8'(NUM_REGS)) begin
								n.regs[r.idx[3:0]] =
									(r.regs[r.idx[3:0]] &
									~RW_MASK[r.idx[3:0]]) |
									(r.sh & RW_MASK[r.idx[3:0]]);
							end
							n.idx = r.idx + 8'h01;
						end
					endcase
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					n.oe = 1'b0;
					if (r.rd_mode) begin
						do_load = 1'b1;
					end else begin
						n.st = ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (r.bit_cnt == LAST_TX_BIT) begin
						n.oe = 1'b0;
						n.st = ST_RACK;
					end else begin
						n.sh      = {r.sh[6:0], 1'b0};
						n.oe      = ~r.sh[6];
						n.bit_cnt = r.bit_cnt + 4'h1;
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					n.ack_ok = ~sda_s;
					// Nack ends the read; wait for stop or restart
					if (sda_s) begin
						n.st = ST_IDLE;
					end
				end else if (scl_fall && r.ack_ok) begin
					do_load = 1'b1;
				end
			end
			default: begin
				n.st = ST_IDLE;
				n.oe = 1'b0;
			end
		endcase

		if (do_load) begin
			n.st      = ST_TX;
			n.bit_cnt = 4'h0;
			if (r.role == RO_COUNT) begin
				n.sh   = r.regs[IDX_COUNT];
				n.role = RO_DATA;
			end else begin
				n.sh  = reg_read(r.regs, r.idx);
				n.idx = r.idx + 8'h01;
			end
			n.oe = ~n.sh[7];
		end

		// Start and stop win over any byte in flight
		if (start_c) begin
			n.st      = ST_RX;
			n.role    = RO_ADDR;
			n.bit_cnt = 4'h0;
			n.oe      = 1'b0;
		end else if (stop_c) begin
			n.st = ST_IDLE;
			n.oe = 1'b0;
		end

		// Output clocks: divider gives a one-cycle toggle enable
		if (r.div == DIV_LAST) begin
			n.div   = '0;
			n.phase = ~r.phase;
		end else begin
			n.div = r.div + DIV_W'(1);
		end
		for (int i = 0; i < 6; i++) begin
			n.tru[i] = en[i] & n.phase;
			n.cmp[i] = en[i] & ~n.phase;
		end
		n.spread = r.regs[IDX_CTRL][SPREAD_BIT];
		n.amp    = {r.regs[IDX_AMP][AMP_HI_LSB +: 2],
			r.regs[IDX_AMP][AMP_MD_LSB +: 2],
			r.regs[IDX_AMP][AMP_LO_LSB +: 2]};
	end

	// ============================================================
	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r         <= '0;
			r.st      <= ST_IDLE;
			r.role    <= RO_ADDR;
			r.scl_d   <= 1'b1;
			r.sda_d   <= 1'b1;
			r.regs    <= RST_VAL;
			r.spread  <= RST_VAL[IDX_CTRL][SPREAD_BIT];
			r.amp     <= {RST_VAL[IDX_AMP][AMP_HI_LSB +: 2],
				RST_VAL[IDX_AMP][AMP_MD_LSB +: 2],
				RST_VAL[IDX_AMP][AMP_LO_LSB +: 2]};
		end else begin
			r <= n;
		end
	end

	// Open-drain: only ever pull low
	assign smb_data_out         = 1'b0;
	assign smb_data_oe          = r.oe;
	assign diff_clock_pair_true = r.tru;
	assign diff_clock_pair_comp = r.cmp;
	assign spread_enable        = r.spread;
	assign amp_hi               = r.amp[5:4];
	assign amp_mid              = r.amp[3:2];
	assign amp_lo               = r.amp[1:0];

	// ============================================================
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	ack_drive_a: assert property (
		(r.st == ST_ACK) |-> smb_data_oe)
		else $error("Acknowledge slot not driven low");

	data_ack_a: assert property (
		(rx_done && r.role == RO_DATA && !start_c && !stop_c) |=>
		(r.st == ST_ACK && smb_data_oe))
		else $error("Data byte not acknowledged");

	addr_match_a: assert property (
		(rx_done && r.role == RO_ADDR && r.sh != ADDR_WR &&
		r.sh != ADDR_RD && !start_c) |=>
		(r.st == ST_IDLE && !smb_data_oe))
		else $error("Foreign address acknowledged");

	count_first_a: assert property (
		(r.st == ST_ACK && r.rd_mode && r.role == RO_COUNT &&
		scl_fall && !start_c && !stop_c) |=>
		(r.st == ST_TX && r.sh == $past(r.regs[IDX_COUNT]) &&
		smb_data_oe == ~r.sh[7]))
		else $error("Read did not open with count byte");

	idx_step_a: assert property (
		(rx_done && r.role == RO_DATA && !start_c) |=>
		(r.idx == $past(r.idx) + 8'h01))
		else $error("Index did not advance after write");

	rsvd_hold_a: assert property (
		((r.regs & ~RW_MASK) == (RST_VAL & ~RW_MASK)))
		else $error("Reserved bits changed");

	pair_low_a: assert property (
		(!en[0]) |=> (!diff_clock_pair_true[0] &&
		!diff_clock_pair_comp[0]))
		else $error("Disabled pair not held low");

	spread_map_a: assert property (
		spread_enable == $past(r.regs[IDX_CTRL][SPREAD_BIT]))
		else $error("Spread enable not following register");

	oe_only_a: assert property (
		smb_data_oe |-> (r.st == ST_ACK || r.st == ST_TX))
		else $error("Data line driven outside ack or transmit");

	stop_idle_a: assert property (
		(stop_c && !start_c) |=> (r.st == ST_IDLE && !smb_data_oe))
		else $error("Stop did not release the bus");

	tx_hold_a: assert property (
		(r.st == ST_TX && !scl_fall && !start_c && !stop_c) |=>
		$stable(smb_data_oe))
		else $error("Sent bit changed while clock high");

	reg_send_a: assert property (
		(r.st == ST_RACK && scl_fall && r.ack_ok && !start_c &&
		!stop_c && r.idx <= IDX_OEC && r.idx != IDX_ID) |=>
		(r.sh == $past(r.regs[r.idx[3:0]])))
		else $error("Sent byte differs from register");

	id_read_a: assert property (
		(r.st == ST_RACK && scl_fall && r.ack_ok && !start_c &&
		!stop_c && r.idx == IDX_ID) |=>
		(r.sh == {REV_ID, VEN_ID}))
		else $error("Identification byte wrong");

	tx_index_a: assert property (
		(r.st == ST_RACK && scl_fall && r.ack_ok && !start_c &&
		!stop_c) |=>
		(r.st == ST_TX && r.idx == $past(r.idx) + 8'h01))
		else $error("Index did not advance after send");

	pairs_off_a: assert property (
		(en != 6'h3f) |=> ((~$past(en) &
		(diff_clock_pair_true | diff_clock_pair_comp)) == 6'h00))
		else $error("Disabled pair not low");

	pairs_run_a: assert property (
		(en != 6'h00) |=> (($past(en) &
		~(diff_clock_pair_true ^ diff_clock_pair_comp)) == 6'h00))
		else $error("Enabled pair not complementary");

	amp_map_a: assert property (
		{amp_hi, amp_mid, amp_lo} ==
		$past({r.regs[IDX_AMP][AMP_HI_LSB +: 2],
		r.regs[IDX_AMP][AMP_MD_LSB +: 2],
		r.regs[IDX_AMP][AMP_LO_LSB +: 2]}))
		else $error("Amplitude ports not following register");

endmodule : scc_regs

// ==== scc_regs_tb_top.sv ====
module scc_regs_tb_top
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 30000;
	// Arbitrary identification values
	localparam logic [3:0] REV = 4'h5;
	localparam logic [3:0] VEN = 4'hc;
	// Index, byte written, byte read back
	localparam logic [23:0] ROWS [12] = '{24'h00ff20, 24'h000000,
		24'h01ff48, 24'h02ff00, 24'h03ffc0, 24'h04a500, 24'h05fff3,
		24'h053c30, 24'h06ff00, 24'h07005c, 24'h09ff60, 24'h090000};
	// Count byte, then bytes 0 to 9 after reset
	localparam logic [7:0] DEFS [11] = '{8'h09, 8'h20, 8'h48, 8'h00,
		8'hc0, 8'h00, 8'h51, 8'h00, 8'h5c, 8'h09, 8'h60};

	logic       ref_clk;
	logic       arst_n;
	logic       smb_clk;
	logic       host_low;
	logic       data_oe;
	logic       sdo;
	logic [5:0] pt;
	logic [5:0] pc;
	logic       spread;
	logic [1:0] ah;
	logic [1:0] am;
	logic [1:0] al;
	wire logic  line;
	int         n_errors;
	int         samples_checked;
	int         cycles = 0;
	logic [7:0] wbuf [4];
	logic [7:0] ebuf [11];

	// Open drain with pull-up
	assign line = ~(host_low | (data_oe & ~sdo));

	scc_host HOST (.ref_clk(ref_clk), .line(line), .smb_clk(smb_clk),
		.host_low(host_low));

	scc_regs #(.REV_ID(REV), .VEN_ID(VEN), .DIV(2)) DUT (
		.ref_clk(ref_clk), .arst_n(arst_n), .smb_clk(smb_clk),
		.smb_data_in(line), .smb_data_out(sdo), .smb_data_oe(data_oe),
		.diff_clock_pair_true(pt), .diff_clock_pair_comp(pc),
		.spread_enable(spread), .amp_hi(ah), .amp_mid(am), .amp_lo(al));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			close_out();
		end
	end

	// ========================================
	// Checking and transfer tasks
	task automatic close_out();
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task automatic wr_blk(input logic [7:0] adr, input logic [7:0] n,
		input int x, input logic ack_exp);
		logic a;
		HOST.start();
		HOST.wr_byte(adr, a);
		chk_bit(a, ack_exp);
		if (ack_exp) begin
			HOST.wr_byte(n, a);
			chk_bit(a, 1'b1);
			HOST.wr_byte(x[7:0], a);
			chk_bit(a, 1'b1);
			for (int i = 0; i < x; i++) begin
				HOST.wr_byte(wbuf[i], a);
				chk_bit(a, 1'b1);
			end
		end
		HOST.stop();
	endtask : wr_blk

	task automatic rd_blk(input logic [7:0] n, input int x);
		logic       a;
		logic [7:0] d;
		HOST.start();
		HOST.wr_byte(ADDR_WR, a);
		chk_bit(a, 1'b1);
		HOST.wr_byte(n, a);
		chk_bit(a, 1'b1);
		HOST.rstart();
		HOST.wr_byte(ADDR_RD, a);
		chk_bit(a, 1'b1);
		HOST.rd_byte(1'b0, d);
		chk_byte(d, ebuf[0]);
		for (int i = 1; i <= x; i++) begin
			HOST.rd_byte(i == x, d);
			chk_byte(d, ebuf[i]);
		end
		HOST.stop();
	endtask : rd_blk

	// Both pair lines, true and complement, each seen high over eight cycles
	task automatic chk_pairs(input logic [5:0] exp);
		logic [5:0] t;
		logic [5:0] c;
		t = 6'h00;
		c = 6'h00;
		repeat (8) begin
			@(negedge ref_clk);
			t |= pt;
			c |= pc;
		end
		chk_byte({2'b00, t}, {2'b00, exp});
		chk_byte({2'b00, c}, {2'b00, exp});
	endtask : chk_pairs

	task automatic do_reset();
		@(negedge ref_clk);
		arst_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask : do_reset

	task automatic chk_defaults();
		ebuf = DEFS;
		rd_blk(IDX_CTRL, 10);
		chk_byte({7'h00, spread}, 8'h01);
		chk_byte({2'b00, ah, am, al}, 8'h15);
	endtask : chk_defaults

	// ========================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		do_reset();
		chk_defaults();
		chk_pairs(6'h3f);
		foreach (ROWS[r]) begin
			wbuf[0] = ROWS[r][15:8];
			wr_blk(ADDR_WR, ROWS[r][23:16], 1, 1'b1);
			ebuf[0] = 8'h09;
			ebuf[1] = ROWS[r][7:0];
			rd_blk(ROWS[r][23:16], 1);
		end
		chk_byte({7'h00, spread}, 8'h00);
		chk_byte({2'b00, ah, am, al}, 8'h0c);
		chk_pairs(6'h33);
		wbuf = '{8'h7f, 8'hff, 8'hc2, 8'h00};
		wr_blk(ADDR_WR, IDX_OEB, 3, 1'b1);
		ebuf[0] = 8'h09;
		ebuf[1] = 8'h40;
		ebuf[2] = 8'h00;
		ebuf[3] = 8'hc2;
		rd_blk(IDX_OEB, 3);
		chk_pairs(6'h13);
		wr_blk(8'ha6, IDX_CTRL, 1, 1'b0);
		wbuf[0] = 8'h04;
		wr_blk(ADDR_WR, IDX_COUNT, 1, 1'b1);
		ebuf[0] = 8'h04;
		ebuf[1] = 8'h00;
		ebuf[2] = 8'h48;
		rd_blk(IDX_CTRL, 2);
		do_reset();
		chk_defaults();
		close_out();
	end

endmodule : scc_regs_tb_top

// ==== scc_sync.sv ====
module scc_sync #(
	parameter int W = 2
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// ============================================================
	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '1;
			dout   <= '1;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule : scc_sync
